// *** acd_backend.sv ***
// Converter back end: input select, offset/gain correction, and sample store channel.
// Assumes raw results arrive as one-cycle strobes and memory accepts a write on ready.
// Writes land at the edge where the master sees ack.
// The request line is a masked OR of the flags.
// A reset or disable drops any store still waiting.
//
// Notes on behaviour
// [RQ1] A pad in analog mode has no digital function; its input reads 1.
// [RQ2] Reference drives its pad only when converter enabled and pad analog.
// [RQ3] First correction adds signed 16-bit offset to the raw signed result.
// [RQ4] Gain product clamps to 0x7fff or 0x8000 and sets saturation flag.
// [RQ5] Corrected value is halved by arithmetic right shift for final sample.
// [RQ6] Gain is unsigned fixed point: bit 15 integer, bits 14:0 fraction.
// [RQ7] Reset clears offset to zero and sets gain to 0x8000.
// [RQ8] The channel stores corrected results, never raw ones.
// [RQ9] Software keeps the buffer start address even.
// [RQ10] Buffer size counts 16-bit samples.
// [RQ11] Channel is reset by its reset bit, then starts only after load.
// [RQ12] Wrap select 0 gives linear fill, 1 gives wrap-around fill.
// [RQ13] Linear mode stops at the sample count and sets full flag.
// [RQ14] After a linear stop, further results set the overflow flag.
// [RQ15] Wrap mode reloads the pointer at buffer end and keeps storing.
// [RQ16] Half flag on filling lower half, full flag on filling upper half.
// [RQ17] Current write address is readable in the pointer register.
// [RQ18] Four-bit selects: 0-5 external, 8 gnd, 9 half ref, 10 ref, 11 half supply.
// [RQ19] Input stage is differential; single-ended uses half reference as one input.
// [RQ20] Software writes the converter configuration last.
// [RQ21] Once enabled, conversions run back to back until disabled.
// [RQ22] Writing 1 to a flag bit clears it; writing 0 leaves it.
// [RQ23] Only flags with mask bit 1 reach the interrupt request.
// [RQ24] Data-ready flag sets whenever a new corrected result is available.
// [RQ25] Pointer advances by two bytes per stored halfword.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module acd_backend #(
  parameter int ADDR_W = 32,
  parameter int NPADS = 7
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Wishbone classic slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Modulator side.
  input wire logic i_raw_valid,
  input wire logic [15:0] i_raw_data,
  output logic o_conv_enable,
  output logic [acd_pkg::ACD_NSRC-1:0] o_pos_source,
  output logic [acd_pkg::ACD_NSRC-1:0] o_neg_source,
  // Pads.
  input wire logic [NPADS-1:0] i_pad_digital_in,
  output logic [NPADS-1:0] o_pad_input_value,
  output logic [NPADS-1:0] o_pad_digital_allow,
  output logic o_reference_output_pad_en,
  // Memory write port.
  output logic o_mem_valid,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [15:0] o_mem_data,
  input wire logic i_mem_ready,
  output logic o_irq
);
  localparam int ACD_NSRC_W = acd_pkg::ACD_NSRC;
  localparam int REF_PAD = 0;

  // Refuse sizes the logic cannot serve.
  if (ADDR_W < 2 || ADDR_W > 32 || NPADS < 1 || NPADS > 16)
  begin : g_bad_params
    $error("acd_backend: unsupported parameter values");
  end

  // Register state.
  logic [31:0] cfg;
  logic [15:0] offset_correction;
  logic [15:0] gain_correction;
  logic [15:0] data_result;
  logic [acd_pkg::ACD_NFLAGS-1:0] converter_event_flags;
  logic [acd_pkg::ACD_NFLAGS-1:0] converter_event_mask;
  logic [ADDR_W-1:0] buffer_start_address;
  logic [15:0] buffer_sample_count;
  logic dma_wrap_select;
  logic dma_running;
  logic [ADDR_W-1:0] dma_current_pointer;
  logic [15:0] dma_index;
  logic [NPADS-1:0] pad_analog;
  logic [15:0] corr_sample;
  logic corr_sat;
  logic corr_valid;

  // Decode a four-bit input select code into a one-hot source vector.
  // Codes 6, 7 and 12 to 15 mean no connection.
  function automatic logic [ACD_NSRC_W-1:0] decode_source(input logic [3:0] code);
    logic [ACD_NSRC_W-1:0] v;
    v = '0;
    if (code <= acd_pkg::ACD_SEL_EXT_MAX)
      v[code] = 1'b1; // [RQ18]
    else if (code == acd_pkg::ACD_SEL_GND)
      v[6] = 1'b1;
    else if (code == acd_pkg::ACD_SEL_HALF_REF)
      v[7] = 1'b1; // [RQ19]
    else if (code == acd_pkg::ACD_SEL_REF)
      v[8] = 1'b1;
    else if (code == acd_pkg::ACD_SEL_HALF_SUP)
      v[9] = 1'b1;
    return v;
  endfunction : decode_source

  // Apply byte enables to a register write.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction : merge_bytes

  // Both inputs are always decoded, so any single-ended setup is just one side at half ref.
  // Enable also keeps the modulator converting.
  assign o_conv_enable = cfg[acd_pkg::ACD_CFG_EN]; // [RQ21]
  assign o_pos_source = decode_source(cfg[acd_pkg::ACD_CFG_MUXP_LSB +: 4]); // [RQ18]
  assign o_neg_source = decode_source(cfg[acd_pkg::ACD_CFG_MUXN_LSB +: 4]); // [RQ19]

  // Analog pads lose digital use and read as one.
  // A digital pad never meets the reference.
  assign o_pad_input_value = i_pad_digital_in | pad_analog; // [RQ1]
  assign o_pad_digital_allow = ~pad_analog; // [RQ1]
  assign o_reference_output_pad_en = cfg[acd_pkg::ACD_CFG_EN] & pad_analog[REF_PAD]; // [RQ2]
  assign o_irq = |(converter_event_flags & converter_event_mask); // [RQ23]

  // Bus strobes.
  // A write lands on the ack edge, its request still standing.
  logic wb_req;
  logic wr;
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we;

  // Correction datapath: offset add, fixed-point gain, clamp, halve; one stage registered.
  // Wide sum and product let the clamp see the true value.
  // Gain is unsigned, so its top bit is not a sign.
  logic signed [16:0] sum;
  logic signed [34:0] prod;
  logic signed [34:0] scaled;
  logic signed [15:0] clamped;
  logic sat_now;
  always_comb
  begin
    sum = $signed({i_raw_data[15], i_raw_data}) +
          $signed({offset_correction[15], offset_correction}); // [RQ3]
    prod = 35'(sum) * $signed({2'b00, gain_correction}); // [RQ6]
    scaled = prod >>> 15; // [RQ6]
    sat_now = 1'b0;
    if (scaled > 35'sd32767)
    begin
      clamped = acd_pkg::ACD_SAT_POS; // [RQ4]
      sat_now = 1'b1;
    end
    else if (scaled < -35'sd32768)
    begin
      clamped = acd_pkg::ACD_SAT_NEG; // [RQ4]
      sat_now = 1'b1;
    end
    else
      clamped = scaled[15:0];
  end

  // Register the final sample; the halving is an arithmetic shift.
  // Only this corrected sample feeds the store channel.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      corr_valid <= 1'b0;
      corr_sample <= 16'h0000;
      corr_sat <= 1'b0;
    end
    else
    begin
      corr_valid <= i_raw_valid;
      corr_sat <= i_raw_valid & sat_now;
      if (i_raw_valid)
        corr_sample <= 16'(clamped >>> 1); // [RQ5]
    end
  end

  // Result register for software reads.
  // It holds until the next result replaces it.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      data_result <= 16'h0000;
    else if (corr_valid)
      data_result <= corr_sample;
  end

  // Software-written configuration.
  // Byte enables apply per lane.
  // Reset makes the correction neutral: gain one, offset zero.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      cfg <= 32'h0000_0000;
      offset_correction <= acd_pkg::ACD_OFFSET_RESET; // [RQ7]
      gain_correction <= acd_pkg::ACD_GAIN_RESET; // [RQ7]
      converter_event_mask <= '0;
      buffer_start_address <= '0;
      buffer_sample_count <= 16'h0000;
      dma_wrap_select <= 1'b0;
      pad_analog <= '0;
    end
    else if (wr)
    begin
      unique case (i_wb_adr)
        acd_pkg::ACD_REG_CONFIG: cfg <= merge_bytes(cfg, i_wb_dat, i_wb_sel);
        acd_pkg::ACD_REG_OFFSET:
          offset_correction <= 16'(merge_bytes({16'h0, offset_correction}, i_wb_dat, i_wb_sel));
        acd_pkg::ACD_REG_GAIN:
          gain_correction <= 16'(merge_bytes({16'h0, gain_correction}, i_wb_dat, i_wb_sel));
        acd_pkg::ACD_REG_MASK:
          if (i_wb_sel[0])
            converter_event_mask <= i_wb_dat[acd_pkg::ACD_NFLAGS-1:0];
        acd_pkg::ACD_REG_BUF_START:
          buffer_start_address <= ADDR_W'(merge_bytes(32'(buffer_start_address),
                                                      i_wb_dat, i_wb_sel)); // [RQ9]
        acd_pkg::ACD_REG_BUF_COUNT:
          buffer_sample_count <= 16'(merge_bytes({16'h0, buffer_sample_count}, i_wb_dat,
                                                 i_wb_sel)); // [RQ10]
        acd_pkg::ACD_REG_DMA_CFG:
          if (i_wb_sel[0])
            dma_wrap_select <= i_wb_dat[acd_pkg::ACD_DMA_WRAP]; // [RQ12]
        acd_pkg::ACD_REG_PAD:
          pad_analog <= NPADS'(merge_bytes(32'(pad_analog), i_wb_dat, i_wb_sel));
        default: ;
      endcase
    end
  end

  // Sample store channel.
  // Half and full compare the next index.
  logic dma_cfg_wr;
  logic dma_rst_cmd;
  logic dma_load_cmd;
  logic store_done;
  logic at_half;
  logic at_end;
  assign dma_cfg_wr = wr & (i_wb_adr == acd_pkg::ACD_REG_DMA_CFG) & i_wb_sel[0];
  assign dma_rst_cmd = dma_cfg_wr & i_wb_dat[acd_pkg::ACD_DMA_RST];
  assign dma_load_cmd = dma_cfg_wr & i_wb_dat[acd_pkg::ACD_DMA_LOAD] & ~dma_rst_cmd;
  assign store_done = o_mem_valid & i_mem_ready;
  assign at_half = (dma_index + 16'h0001) == (buffer_sample_count >> 1);
  assign at_end = (dma_index + 16'h0001) == buffer_sample_count;
  // Besides reset, the reset bit, a linear end and a load with a zero count, only a write clearing enable stops the
  // channel, so a load made before enable survives.
  logic conv_off_cmd;
  assign conv_off_cmd = wr & (i_wb_adr == acd_pkg::ACD_REG_CONFIG) & i_wb_sel[0] &
                        ~i_wb_dat[acd_pkg::ACD_CFG_EN];

  // Channel state; a result arriving while a store is pending is dropped, since memory
  // is expected to accept within one conversion time.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      dma_running <= 1'b0;
      dma_current_pointer <= '0;
      dma_index <= 16'h0000;
      o_mem_valid <= 1'b0;
      o_mem_addr <= '0;
      o_mem_data <= 16'h0000;
    end
    else if (dma_rst_cmd || conv_off_cmd)
    begin
      dma_running <= 1'b0; // [RQ11]
      o_mem_valid <= 1'b0;
      dma_index <= 16'h0000;
      if (dma_rst_cmd)
        dma_current_pointer <= buffer_start_address;
    end
    else if (dma_load_cmd)
    begin
      dma_running <= (buffer_sample_count != 16'h0000); // [RQ11]
      dma_current_pointer <= buffer_start_address;
      dma_index <= 16'h0000;
    end
    else
    begin
      if (corr_valid && dma_running && !o_mem_valid)
      begin
        o_mem_valid <= 1'b1;
        o_mem_addr <= dma_current_pointer;
        o_mem_data <= corr_sample; // [RQ8]
      end
      else if (store_done)
      begin
        o_mem_valid <= 1'b0;
        if (at_end)
        begin
          dma_index <= 16'h0000;
          dma_current_pointer <= buffer_start_address; // [RQ15]
          dma_running <= dma_wrap_select; // [RQ13]
        end
        else
        begin
          dma_index <= dma_index + 16'h0001;
          dma_current_pointer <= dma_current_pointer + ADDR_W'(2); // [RQ25]
        end
      end
    end
  end

  // Event flags: hardware set wins over a software clear in the same cycle.
  // A written one clears; a zero leaves the flag.
  logic [acd_pkg::ACD_NFLAGS-1:0] flag_set;
  logic [acd_pkg::ACD_NFLAGS-1:0] flag_clr;
  always_comb
  begin
    flag_set = '0;
    flag_set[acd_pkg::ACD_FLG_DATA] = corr_valid; // [RQ24]
    flag_set[acd_pkg::ACD_FLG_SAT] = corr_sat; // [RQ4]
    flag_set[acd_pkg::ACD_FLG_HALF] = store_done & at_half; // [RQ16]
    flag_set[acd_pkg::ACD_FLG_FULL] = store_done & at_end; // [RQ13]
    flag_set[acd_pkg::ACD_FLG_OVF] = corr_valid & ~dma_running & cfg[acd_pkg::ACD_CFG_EN]; // [RQ14]
    flag_clr = '0;
    if (wr && i_wb_adr == acd_pkg::ACD_REG_FLAGS && i_wb_sel[0])
      flag_clr = i_wb_dat[acd_pkg::ACD_NFLAGS-1:0]; // [RQ22]
  end

  // Flag register.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      converter_event_flags <= '0;
    else
      converter_event_flags <= (converter_event_flags & ~flag_clr) | flag_set; // [RQ22]
  end

  // Bus answer: ack one cycle after the request, read data registered with it.
  // Unmapped offsets read zero and still get ack.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we)
      begin
        unique case (i_wb_adr)
          acd_pkg::ACD_REG_CONFIG: o_wb_dat <= cfg;
          acd_pkg::ACD_REG_OFFSET: o_wb_dat <= {16'h0000, offset_correction};
          acd_pkg::ACD_REG_GAIN: o_wb_dat <= {16'h0000, gain_correction};
          acd_pkg::ACD_REG_DATA: o_wb_dat <= {16'h0000, data_result};
          acd_pkg::ACD_REG_FLAGS: o_wb_dat <= 32'(converter_event_flags);
          acd_pkg::ACD_REG_MASK: o_wb_dat <= 32'(converter_event_mask);
          acd_pkg::ACD_REG_BUF_START: o_wb_dat <= 32'(buffer_start_address);
          acd_pkg::ACD_REG_BUF_COUNT: o_wb_dat <= {16'h0000, buffer_sample_count};
          // Running reads in bit 7, wrap in bit 1.
          acd_pkg::ACD_REG_DMA_CFG:
            o_wb_dat <= 32'({dma_running, 3'b000, 2'b00, dma_wrap_select, 1'b0});
          acd_pkg::ACD_REG_DMA_CUR: o_wb_dat <= 32'(dma_current_pointer); // [RQ17]
          acd_pkg::ACD_REG_PAD: o_wb_dat <= 32'(pad_analog);
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : acd_backend

// *** acd_pkg.sv ***
// Package for the converter correction and sample store back end.
// Assumes a Wishbone classic slave with 32-bit data and word-aligned registers.
package acd_pkg;
  // Register byte offsets.
  localparam logic [7:0] ACD_REG_CONFIG = 8'h00;
  localparam logic [7:0] ACD_REG_OFFSET = 8'h04;
  localparam logic [7:0] ACD_REG_GAIN = 8'h08;
  localparam logic [7:0] ACD_REG_DATA = 8'h0c;
  localparam logic [7:0] ACD_REG_FLAGS = 8'h10;
  localparam logic [7:0] ACD_REG_MASK = 8'h14;
  localparam logic [7:0] ACD_REG_BUF_START = 8'h18;
  localparam logic [7:0] ACD_REG_BUF_COUNT = 8'h1c;
  localparam logic [7:0] ACD_REG_DMA_CFG = 8'h20;
  localparam logic [7:0] ACD_REG_DMA_CUR = 8'h24;
  localparam logic [7:0] ACD_REG_PAD = 8'h28;
  // Reset values and clamp limits.
  localparam logic [15:0] ACD_OFFSET_RESET = 16'h0000;
  localparam logic [15:0] ACD_GAIN_RESET = 16'h8000;
  localparam logic [15:0] ACD_SAT_POS = 16'h7fff;
  localparam logic [15:0] ACD_SAT_NEG = 16'h8000;
  // Config register fields.
  localparam int ACD_CFG_EN = 0;
  localparam int ACD_CFG_MUXN_LSB = 4;
  localparam int ACD_CFG_MUXP_LSB = 8;
  // DMA config fields.
  localparam int ACD_DMA_LOAD = 0;
  localparam int ACD_DMA_WRAP = 1;
  localparam int ACD_DMA_RST = 4;
  // Event flag positions.
  localparam int ACD_FLG_DATA = 0;
  localparam int ACD_FLG_HALF = 1;
  localparam int ACD_FLG_FULL = 2;
  localparam int ACD_FLG_SAT = 3;
  localparam int ACD_FLG_OVF = 4;
  localparam int ACD_NFLAGS = 5;
  // Input select codes.
  localparam logic [3:0] ACD_SEL_EXT_MAX = 4'h5;
  localparam logic [3:0] ACD_SEL_GND = 4'h8;
  localparam logic [3:0] ACD_SEL_HALF_REF = 4'h9;
  localparam logic [3:0] ACD_SEL_REF = 4'ha;
  localparam logic [3:0] ACD_SEL_HALF_SUP = 4'hb;
  // Decoded source one-hot: bits 0..5 external, 6 gnd, 7 half ref, 8 ref, 9 half supply.
  localparam int ACD_NSRC = 10;
endpackage : acd_pkg

// *** acd_backend_properties.sv ***
// Concurrent checks on the converter back end, bound to every instance.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module acd_backend_properties #(
  parameter int ADDR_W = 32,
  parameter int NPADS = 7
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_raw_valid,
  input wire logic o_conv_enable,
  input wire logic [acd_pkg::ACD_NSRC-1:0] o_pos_source,
  input wire logic [acd_pkg::ACD_NSRC-1:0] o_neg_source,
  input wire logic [NPADS-1:0] i_pad_digital_in,
  input wire logic [NPADS-1:0] o_pad_input_value,
  input wire logic [NPADS-1:0] o_pad_digital_allow,
  input wire logic o_reference_output_pad_en,
  input wire logic o_mem_valid,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [15:0] o_mem_data,
  input wire logic i_mem_ready,
  input wire logic o_irq
);
  // A single domain, so clock and reset are stated once for all checks.
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  a_ack_follows_req: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered");
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_pad_reads_one: assert property (&(o_pad_input_value | o_pad_digital_allow))
    else $error("analog pad input not one");
  a_pad_digital_pass: assert property (
    (o_pad_digital_allow & (o_pad_input_value ^ i_pad_digital_in)) == '0)
    else $error("digital pad level lost");
  a_ref_pad_gate: assert property (
    o_reference_output_pad_en == (o_conv_enable && !o_pad_digital_allow[0]))
    else $error("reference pad gating wrong");
  a_source_one_hot: assert property ($onehot0(o_pos_source) && $onehot0(o_neg_source))
    else $error("source select not one-hot");
  a_store_after_result: assert property ($rose(o_mem_valid) |-> $past(i_raw_valid, 2))
    else $error("store without a result");
  a_store_holds: assert property (o_mem_valid && !i_mem_ready |=>
    o_mem_valid && $stable(o_mem_addr) && $stable(o_mem_data))
    else $error("store request changed before ready");
  a_store_even: assert property (o_mem_valid |-> !o_mem_addr[0])
    else $error("odd store address");
  c_ref_pad: cover property (o_reference_output_pad_en);
  c_store_taken: cover property (o_mem_valid && i_mem_ready);
  c_irq_raised: cover property (o_irq);
endmodule : acd_backend_properties

bind acd_backend acd_backend_properties #(.ADDR_W(ADDR_W), .NPADS(NPADS)) i_props (
  .i_core_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_raw_valid, .o_conv_enable,
  .o_pos_source, .o_neg_source, .i_pad_digital_in, .o_pad_input_value,
  .o_pad_digital_allow, .o_reference_output_pad_en, .o_mem_valid, .o_mem_addr,
  .o_mem_data, .i_mem_ready, .o_irq);

// *** acd_partner.sv ***
// Behavioural modulator and sample memory facing the back end.
// Assumes results are wanted as one-cycle strobes spaced GAP cycles.
`timescale 1ns/1ps
module acd_partner #(
  parameter int ADDR_W = 32,
  parameter int GAP = 12
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_conv_enable,
  input wire logic i_wide,
  input wire logic [1:0] i_slow,
  output logic o_raw_valid,
  output logic [15:0] o_raw_data,
  input wire logic i_mem_valid,
  input wire logic [ADDR_W-1:0] i_mem_addr,
  input wire logic [15:0] i_mem_data,
  output logic o_mem_ready,
  output logic o_wr,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [15:0] o_wr_data
);
  int gap_cnt = 0;
  int wait_cnt = 0;
  int seed = 41;
  logic [15:0] r;
  // Results run back to back while enabled; idle data toggles so nothing stale looks valid.
  always @(posedge i_core_clk)
  begin
    o_raw_valid <= 1'b0;
    o_raw_data <= i_reset ? 16'h5a5a : ~o_raw_data;
    if (i_reset || !i_conv_enable)
      gap_cnt <= 0;
    else if (gap_cnt == GAP - 1)
    begin
      r = 16'($random(seed));
      gap_cnt <= 0;
      o_raw_valid <= 1'b1;
      o_raw_data <= i_wide ? r : {r[14], r[14:0]};
    end
    else
      gap_cnt <= gap_cnt + 1;
  end
  // Memory answers after i_slow idle cycles and reports each accepted store.
  always @(posedge i_core_clk)
  begin
    o_mem_ready <= 1'b0;
    o_wr <= 1'b0;
    if (i_mem_valid && o_mem_ready)
    begin
      o_wr <= 1'b1;
      o_wr_addr <= i_mem_addr;
      o_wr_data <= i_mem_data;
      wait_cnt <= 0;
    end
    else if (i_mem_valid && wait_cnt >= int'(i_slow))
      o_mem_ready <= 1'b1;
    else if (i_mem_valid)
      wait_cnt <= wait_cnt + 1;
  end
endmodule : acd_partner

// *** acd_backend_bench.sv ***
// Self-checking bench for the converter back end and its partner model.
// Assumes the package, design, checker and partner are compiled first.
`timescale 1ns/1ps
module acd_backend_bench;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0;
  logic [6:0] i_pad_digital_in = 7'h00;
  logic i_raw_valid, i_mem_ready, o_wb_ack, o_conv_enable, o_mem_valid, o_irq, wr, s;
  logic o_reference_output_pad_en, sat_exp, ovf_exp;
  logic [15:0] i_raw_data, o_mem_data, wr_data, off, gain, last_exp, cv;
  logic [31:0] o_wb_dat, o_mem_addr, wr_addr, rd, start;
  logic [9:0] o_pos_source, o_neg_source;
  logic [6:0] o_pad_input_value, o_pad_digital_allow;
  logic wide = 1'b0;
  logic [1:0] slow = 2'd0;
  logic [47:0] e;
  logic [47:0] q[$];
  int fail_count = 0;
  int checked = 0;
  int seed = 41;
  int k, lim, cnt, nraw;

  // Free-running 40 MHz clock.
  always #12.5 i_core_clk = ~i_core_clk;

  acd_backend i_dut (.i_core_clk, .i_reset, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
    .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_raw_valid, .i_raw_data, .o_conv_enable,
    .o_pos_source, .o_neg_source, .i_pad_digital_in, .o_pad_input_value,
    .o_pad_digital_allow, .o_reference_output_pad_en, .o_mem_valid, .o_mem_addr,
    .o_mem_data, .i_mem_ready, .o_irq);
  acd_partner i_far (.i_core_clk, .i_reset, .i_conv_enable(o_conv_enable), .i_wide(wide),
    .i_slow(slow), .o_raw_valid(i_raw_valid), .o_raw_data(i_raw_data),
    .i_mem_valid(o_mem_valid), .i_mem_addr(o_mem_addr), .i_mem_data(o_mem_data),
    .o_mem_ready(i_mem_ready), .o_wr(wr), .o_wr_addr(wr_addr), .o_wr_data(wr_data));

  task automatic give_verdict();
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic timeout();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict();
  endtask : timeout

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One classic cycle; the request stands until ack is seen at an edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    n = 0;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (o_wb_ack !== 1'b1 && n < 20);
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    if (n >= 20) timeout();
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  // Reference arithmetic: wide sum and product so clamping is judged exactly.
  function automatic logic [15:0] corr(input logic [15:0] raw, output logic sat);
    logic signed [16:0] sum;
    logic signed [34:0] p;
    sum = $signed(raw) + $signed(off);
    p = (sum * $signed({1'b0, gain})) >>> 15;
    sat = (p > 35'sd32767) || (p < -35'sd32768);
    if (p > 35'sd32767) p = 35'sd32767;
    if (p < -35'sd32768) p = -35'sd32768;
    return $signed(p[15:0]) >>> 1;
  endfunction : corr

  function automatic logic [9:0] sel_exp(input int c);
    if (c <= 5) return 10'(1 << c);
    if (c >= 8 && c <= 11) return 10'(1 << (c - 2));
    return 10'h000;
  endfunction : sel_exp

  // Pad levels wander every cycle so the analog override is exercised.
  always @(posedge i_core_clk) i_pad_digital_in <= 7'($random(seed));

  // Every result taken while enabled is predicted here, before its store appears.
  always @(posedge i_core_clk)
  begin
    if (i_raw_valid === 1'b1 && o_conv_enable === 1'b1)
    begin
      cv = corr(i_raw_data, s);
      sat_exp = sat_exp | s;
      last_exp = cv;
      nraw++;
      ovf_exp = ovf_exp | (k >= lim);
      if (k < lim)
      begin
        q.push_back({start + 32'(2 * (k % cnt)), cv});
        k++;
      end
    end
  end

  // Each accepted store is matched against the oldest prediction.
  always @(posedge i_core_clk)
  begin
    if (wr === 1'b1)
    begin
      e = (q.size() != 0) ? q.pop_front() : 48'h0;
      check(wr_addr, e[47:16]);
      check({16'h0, wr_data}, {16'h0, e[15:0]});
    end
  end

  // Linear runs get a prompt memory, wrap runs a slow one.
  task automatic run(input logic w, input int c, input int n, input logic [15:0] o,
      input logic [15:0] g);
    int j;
    wide <= w;
    slow <= w ? 2'd2 : 2'd0;
    off = o;
    gain = g;
    cnt = c;
    k = 0;
    lim = w ? 1000000 : c;
    nraw = 0;
    sat_exp = 1'b0;
    ovf_exp = 1'b0;
    start = (32'($random(seed)) & 32'h0ffe) | 32'h100;
    wb(1'b1, acd_pkg::ACD_REG_OFFSET, {16'h0, o});
    wb(1'b1, acd_pkg::ACD_REG_GAIN, {16'h0, g});
    wb(1'b1, acd_pkg::ACD_REG_DMA_CFG, 32'h1 << acd_pkg::ACD_DMA_RST);
    wb(1'b1, acd_pkg::ACD_REG_BUF_START, start);
    wb(1'b1, acd_pkg::ACD_REG_BUF_COUNT, 32'(c));
    wb(1'b1, acd_pkg::ACD_REG_DMA_CFG, {30'h0, w, 1'b1});
    wb(1'b1, acd_pkg::ACD_REG_FLAGS, 32'h1f);
    wb(1'b1, acd_pkg::ACD_REG_MASK, 32'h0);
    wb(1'b1, acd_pkg::ACD_REG_CONFIG, 32'h0091);
    @(negedge i_core_clk);
    check({31'h0, o_reference_output_pad_en}, 32'h1);
    j = 0;
    while ((nraw < n || q.size() != 0) && j < 3000)
    begin
      @(posedge i_core_clk);
      j++;
    end
    if (j >= 3000) timeout();
    wb(1'b1, acd_pkg::ACD_REG_CONFIG, 32'h0);
    wb(1'b0, acd_pkg::ACD_REG_DATA, 32'h0);
    check({16'h0, rd[15:0]}, {16'h0, last_exp});
    rd_chk(acd_pkg::ACD_REG_FLAGS, {27'h0, ovf_exp, sat_exp, k >= c, k >= c / 2, 1'b1});
    if (w) rd_chk(acd_pkg::ACD_REG_DMA_CUR, start + 32'(2 * (k % c)));
  endtask : run

  // Main sequence: reset values, select decode, two store runs, flags and mask.
  initial
  begin
    repeat (16) @(posedge i_core_clk);
    i_reset <= 1'b0;
    rd_chk(acd_pkg::ACD_REG_OFFSET, 32'h0);
    rd_chk(acd_pkg::ACD_REG_GAIN, 32'h8000);
    wb(1'b1, 8'h3c, 32'hffffffff);
    rd_chk(8'h3c, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      wb(1'b1, acd_pkg::ACD_REG_CONFIG, {20'h0, 4'(c), 4'(15 - c), 4'h0});
      @(negedge i_core_clk);
      check({22'h0, o_pos_source}, {22'h0, sel_exp(c)});
      check({22'h0, o_neg_source}, {22'h0, sel_exp(15 - c)});
    end
    wb(1'b1, acd_pkg::ACD_REG_PAD, (32'($random(seed)) & 32'h7f) | 32'h1);
    run(1'b0, 4, 6, 16'h0040, 16'h4000 | 16'($random(seed) & 32'h7fff));
    run(1'b1, 3, 7, 16'h0000, 16'hffff);
    wb(1'b1, acd_pkg::ACD_REG_FLAGS, 32'h0);
    rd_chk(acd_pkg::ACD_REG_FLAGS, {27'h0, ovf_exp, sat_exp, 3'b111});
    wb(1'b1, acd_pkg::ACD_REG_FLAGS, 32'h1 << acd_pkg::ACD_FLG_FULL);
    rd_chk(acd_pkg::ACD_REG_FLAGS, {27'h0, ovf_exp, sat_exp, 3'b011});
    wb(1'b1, acd_pkg::ACD_REG_MASK, 32'h1 << acd_pkg::ACD_FLG_HALF);
    @(negedge i_core_clk);
    check({31'h0, o_irq}, 32'h1);
    wb(1'b1, acd_pkg::ACD_REG_MASK, 32'h1 << acd_pkg::ACD_FLG_FULL);
    @(negedge i_core_clk);
    check({31'h0, o_irq}, 32'h0);
    give_verdict();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (60000) @(posedge i_core_clk);
    timeout();
  end
endmodule : acd_backend_bench
